// *** hw/sensor_regs.sv ***
// register bank, sequencer and pin control of the multiturn position sensor
//
// Behaviour
// - angle is a 12-bit code in bits 15:4, 360/4096 degrees each.
// - fault flags come out of reset as all ones.
// - fault flags stay until a zero write; live conditions stay set.
// - turn cross-check, range, decoder, combination or quadrant errors set bit 13.
// - sensor false state, resistor flip, bad direction setting, low turns set bit 9.
// - radius check sets bit 14, double-bit error bit 7, memory CRC bit 5.
// - interface supply over/under in bits 3/2, core supply in bits 1/0.
// - sine and cosine in bits 15:2, preset 0x2000 at start, then updated.
// - bit 0 new-data flag in continuous mode, cleared by read, low in one-shot.
// - radius magnitude sits in bits 15:1.
// - temperature code in bits 15:4, preset 0xfff0 at every sequence start.
// - general configuration resets to 0x1230.
// - sync field 11 aligns sampling to convert edge; 00 and invalid are sequencer-timed.
// - general bit 12 switches the angle filter.
// - general bit 10 picks factory or user eighth-harmonic coefficients.
// - eleven scattered general bits are plain user storage.
// - mode bit zero converts continuously, one stops after one sequence.
// - pin control bits 5:0 turn pins into general-purpose pins.
// - pin control bits 13:8 enable drivers; undriven general-purpose pins are inputs.
// - pin control resets to 0x201f, driving the boot-load output.
// - paged registers need the page field; fault and angle ignore it.
// - configuration changes need the correction disable key written first.
// - writing 00 to convert bits starts a sequence, 11 aborts it.
`timescale 1ns/100ps
module sensor_regs (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // serial link from the host
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // digital pins
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  // boot loader status for pin 5
  input wire logic boot_load_in,
  // measurement front end
  input wire logic meas_valid,
  input wire mt_pkg::meas_t meas,
  input wire mt_pkg::fault_src_t fault_src,
  output logic seq_start,
  output logic seq_abort,
  output mt_pkg::cfg_t cfg,
  output logic ecc_off
);
  typedef struct packed {
    logic [15:0] fault;
    logic [15:0] sine;
    logic [15:0] cosine;
    logic [15:0] radius;
    logic [15:0] temp;
    logic [15:0] angle;
    logic [15:0] general;
    logic [15:0] pinfn;
    logic [15:0] correction_disable_key;
    logic [4:0] page;
    logic [5:0] gpio;
    logic [15:0] rd;
    logic seen;
    mt_pkg::seq_t seq;
    logic done;
    logic start_p;
    logic abort_p;
    logic cnv_prev;
    logic [5:0] pout;
  } state_t;

  // power-on values
  localparam state_t state_rst = '{
    fault: mt_pkg::rst_fault,
    angle: mt_pkg::rst_angle,
    general: mt_pkg::rst_general,
    pinfn: mt_pkg::rst_pinfn,
    seq: mt_pkg::seq_idle,
    default: '0
  };

  state_t state_q, state_d;
  mt_pkg::link_word_t word;
  logic tgl_raw, req_lvl;
  logic [5:0] pin_lvl, gpio_rd, fn_out;
  logic req_new, rd_req, wr_req, p_meas, p_cfg, cfg_ok;
  logic w_cnv, w_fault, w_gpio, w_general, w_pinfn, w_correction_disable_key;
  logic cnv_lvl, cnv_fall, cnv_rise, go, stop, busy, launch;
  logic [1:0] sampling_sync_select;
  logic [15:0] rd_val;

  // address match with the page check folded in
  function automatic logic hit(input logic [6:0] a, input logic [6:0] want, input logic pg_ok);
    return (a == want) && pg_ok;
  endfunction

  // live fault conditions mapped onto flag positions
  function automatic logic [15:0] fault_set(input mt_pkg::fault_src_t s);
    logic [15:0] f;
    f = '0;
    f[mt_pkg::f_cross] = s.turn_mismatch | s.turn_range | s.decoder_split |
                         s.combo_error | s.quadrant_error;
    f[mt_pkg::f_false] = s.false_state | s.ref_flip | s.dir_illegal | s.turn_low;
    f[mt_pkg::f_radius] = s.radius_fail;
    f[mt_pkg::f_ecc2] = s.ecc_double;
    f[mt_pkg::f_crc] = s.nvm_crc;
    f[mt_pkg::f_iov] = s.iface_ov;
    f[mt_pkg::f_iuv] = s.iface_uv;
    f[mt_pkg::f_cov] = s.core_ov;
    f[mt_pkg::f_cuv] = s.core_uv;
    return f;
  endfunction

  // raw trig word: value, a zero reserved bit, then the new-data flag
  function automatic logic [15:0] trig_word(input logic [13:0] v, input logic flag);
    return {v, 1'b0, flag};
  endfunction

  // link side lives on the host clock
  spi_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .reset(reset),
    .miso(miso),
    .miso_oe(miso_oe),
    .req_tgl(tgl_raw),
    .req_word(word),
    .rd_word(state_q.rd)
  );

  // the toggle and the pins both arrive from outside this clock
  bit_sync #(.W(7)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({tgl_raw, pin_in}),
    .level({req_lvl, pin_lvl})
  );

  // request decode; word is steady long before its toggle settles
  assign req_new = req_lvl != state_q.seen;
  assign rd_req = req_new & ~word.wr;
  assign wr_req = req_new & word.wr;
  assign p_meas = state_q.page == mt_pkg::page_meas;
  assign p_cfg = state_q.page == mt_pkg::page_cfg;
  assign cfg_ok = state_q.correction_disable_key == mt_pkg::ecc_key;
  assign w_cnv = wr_req & hit(word.adr, mt_pkg::adr_convert_page_control, 1'b1);
  assign w_gpio = wr_req & hit(word.adr, mt_pkg::adr_gpio, 1'b1);
  assign w_fault = wr_req & hit(word.adr, mt_pkg::adr_fault, 1'b1);
  assign w_correction_disable_key = wr_req & hit(word.adr, mt_pkg::adr_correction_disable_key, p_cfg);
  // without the key a config write would be corrected back, so drop it
  assign w_general = wr_req & hit(word.adr, mt_pkg::adr_general, p_cfg) & cfg_ok;
  assign w_pinfn = wr_req & hit(word.adr, mt_pkg::adr_pinfn, p_cfg) & cfg_ok;

  // convert pin only counts while it holds its function
  assign cnv_lvl = state_q.pinfn[mt_pkg::pin_cnv] ? state_q.cnv_prev : pin_lvl[mt_pkg::pin_cnv];
  assign cnv_fall = state_q.cnv_prev & ~cnv_lvl;
  assign cnv_rise = ~state_q.cnv_prev & cnv_lvl;
  assign go = (w_cnv && word.data[mt_pkg::cnv_hi:mt_pkg::cnv_lo] == mt_pkg::cnv_start)
              || cnv_fall;
  assign stop = (w_cnv && word.data[mt_pkg::cnv_hi:mt_pkg::cnv_lo] == mt_pkg::cnv_abort)
                || cnv_rise;
  assign busy = state_q.seq == mt_pkg::seq_run;

  // read mux; unmapped or off-page addresses answer zero
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      gpio_rd[i] = (state_q.pinfn[i] && state_q.pinfn[mt_pkg::pin_en_lo + i]) ?
                   state_q.gpio[i] : pin_lvl[i];
    end
    rd_val = '0;
    if (hit(word.adr, mt_pkg::adr_convert_page_control, 1'b1)) begin
      rd_val[mt_pkg::page_hi:0] = state_q.page;
    end else if (hit(word.adr, mt_pkg::adr_gpio, 1'b1)) begin
      rd_val[5:0] = gpio_rd;
    end else if (hit(word.adr, mt_pkg::adr_angle, 1'b1)) begin
      rd_val = state_q.angle;
    end else if (hit(word.adr, mt_pkg::adr_fault, 1'b1)) begin
      rd_val = state_q.fault;
    end else if (hit(word.adr, mt_pkg::adr_sine, p_meas)) begin
      rd_val = state_q.sine;
    end else if (hit(word.adr, mt_pkg::adr_cosine, p_meas)) begin
      rd_val = state_q.cosine;
    end else if (hit(word.adr, mt_pkg::adr_radius, p_meas)) begin
      rd_val = state_q.radius;
    end else if (hit(word.adr, mt_pkg::adr_temp, p_meas)) begin
      rd_val = state_q.temp;
    end else if (hit(word.adr, mt_pkg::adr_general, p_cfg)) begin
      rd_val = state_q.general;
    end else if (hit(word.adr, mt_pkg::adr_pinfn, p_cfg)) begin
      rd_val = state_q.pinfn;
    end else if (hit(word.adr, mt_pkg::adr_correction_disable_key, p_cfg)) begin
      rd_val = state_q.correction_disable_key;
    end
  end

  // functional pin drivers and their enables
  always_comb begin
    fn_out = '0;
    fn_out[mt_pkg::pin_boot] = boot_load_in;
    fn_out[mt_pkg::pin_done] = state_q.done;
    fn_out[mt_pkg::pin_busy] = busy;
    for (int i = 0; i < 6; i++) begin
      pin_oe[i] = state_q.pinfn[mt_pkg::pin_en_lo + i] &
                  (state_q.pinfn[i] | mt_pkg::fn_outputs[i]);
    end
  end

  // next state of the whole bank
  always_comb begin
    state_d = state_q;
    launch = 1'b0;
    state_d.seen = req_lvl;
    state_d.start_p = 1'b0;
    state_d.abort_p = 1'b0;
    state_d.cnv_prev = cnv_lvl;
    // a read hands back its word and clears the flag it showed
    if (rd_req) begin
      state_d.rd = rd_val;
      if (hit(word.adr, mt_pkg::adr_sine, p_meas)) begin
        state_d.sine[mt_pkg::flag_bit] = 1'b0;
      end
      if (hit(word.adr, mt_pkg::adr_cosine, p_meas)) begin
        state_d.cosine[mt_pkg::flag_bit] = 1'b0;
      end
      if (hit(word.adr, mt_pkg::adr_radius, p_meas)) begin
        state_d.radius[mt_pkg::flag_bit] = 1'b0;
      end
    end
    // register writes
    if (w_cnv) begin
      state_d.page = word.data[mt_pkg::page_hi:0];
    end
    if (w_gpio) begin
      state_d.gpio = word.data[5:0];
    end
    if (w_general) begin
      state_d.general = word.data;
    end
    if (w_pinfn) begin
      state_d.pinfn = word.data & mt_pkg::mask_pinfn;
    end
    if (w_correction_disable_key) begin
      state_d.correction_disable_key = word.data;
    end
    // only an all-zero write clears; other values leave the flags alone
    if (w_fault && word.data == '0) begin
      state_d.fault = '0;
    end
    // live conditions win over the clear in the same cycle
    state_d.fault = state_d.fault | fault_set(fault_src);
    // sequencer
    case (state_q.seq)
      mt_pkg::seq_idle: begin
        launch = go & ~stop;
      end
      mt_pkg::seq_run: begin
        if (stop) begin
          state_d.seq = mt_pkg::seq_idle;
          state_d.abort_p = 1'b1;
        end else if (go) begin
          launch = 1'b1;
        end else if (meas_valid) begin
          // a result arriving after a read still raises the flag
          state_d.sine = trig_word(meas.sine, ~state_q.general[mt_pkg::gen_mode]);
          state_d.cosine = trig_word(meas.cosine, ~state_q.general[mt_pkg::gen_mode]);
          state_d.radius = {meas.radius, ~state_q.general[mt_pkg::gen_mode]};
          state_d.temp = {meas.temp, 4'h0};
          state_d.angle = {meas.angle, 4'h0};
          state_d.done = 1'b1;
          if (state_q.general[mt_pkg::gen_mode]) begin
            state_d.seq = mt_pkg::seq_idle;
          end
        end
      end
      default: begin
        state_d.seq = mt_pkg::seq_idle;
      end
    endcase
    // a commanded start presets sine, cosine and temperature; continuous repeats do not
    if (launch) begin
      state_d.seq = mt_pkg::seq_run;
      state_d.start_p = 1'b1;
      state_d.done = 1'b0;
      state_d.sine = mt_pkg::preset_trig;
      state_d.cosine = mt_pkg::preset_trig;
      state_d.temp = mt_pkg::preset_temp;
    end
    // one-shot mode keeps every new-data flag low
    if (state_d.general[mt_pkg::gen_mode]) begin
      state_d.sine[mt_pkg::flag_bit] = 1'b0;
      state_d.cosine[mt_pkg::flag_bit] = 1'b0;
      state_d.radius[mt_pkg::flag_bit] = 1'b0;
    end
    // pin data come from a flop, one cycle behind the selection
    for (int i = 0; i < 6; i++) begin
      state_d.pout[i] = state_q.pinfn[i] ? state_q.gpio[i] : fn_out[i];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= state_rst;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs toward the front end
  assign sampling_sync_select = state_q.general[mt_pkg::gen_sync_hi:mt_pkg::gen_sync_lo];
  assign cfg.sample_on_edge = sampling_sync_select == mt_pkg::sync_edge;
  assign cfg.angle_filter_on = state_q.general[mt_pkg::gen_filt];
  assign cfg.eighth_harmonic_source = state_q.general[mt_pkg::gen_h8];
  assign cfg.conversion_mode_select = state_q.general[mt_pkg::gen_mode];
  assign ecc_off = cfg_ok;
  assign seq_start = state_q.start_p;
  assign seq_abort = state_q.abort_p;
  assign pin_out = state_q.pout;

  // checks
  radius_latch_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    fault_src.radius_fail |=> state_q.fault[mt_pkg::f_radius])
    else $error("radius fault not latched");

  cross_check_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (fault_src.turn_range || fault_src.quadrant_error) |=> state_q.fault[mt_pkg::f_cross])
    else $error("turn cross-check fault not latched");

  supply_flag_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    fault_src.iface_uv && !fault_src.core_uv && w_fault && word.data == '0
    |=> state_q.fault[mt_pkg::f_iuv] && !state_q.fault[mt_pkg::f_cuv])
    else $error("supply fault bits wrong after clear");

  fault_clear_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    w_fault && word.data == '0 && fault_src == '0 |=> state_q.fault == '0)
    else $error("fault clear did not empty the register");

  oneshot_flag_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_q.general[mt_pkg::gen_mode] |-> !(state_q.sine[0] || state_q.radius[0]))
    else $error("new-data flag high in one-shot mode");

  trig_preset_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(state_q.start_p) |-> state_q.sine == mt_pkg::preset_trig && busy)
    else $error("sine not preset at sequence start");

  temp_preset_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    state_q.start_p |-> state_q.temp == mt_pkg::preset_temp && !state_q.done)
    else $error("temperature not preset at sequence start");

  oneshot_stop_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    busy && meas_valid && !go && !stop && state_q.general[mt_pkg::gen_mode]
    |=> !busy && !seq_start)
    else $error("one-shot sequence kept running");

  abort_seq_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    busy && stop |=> !busy && seq_abort ##1 !seq_abort)
    else $error("abort did not stop the sequencer");

  page_gate_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    rd_req && word.adr == mt_pkg::adr_temp && !p_meas |=> state_q.rd == '0)
    else $error("paged register read off its page");
endmodule

// *** common/mt_pkg.sv ***
// shared constants and types for the multiturn sensor register block
package mt_pkg;
  // link frame: 1 write flag, 7 address bits, 16 data bits
  localparam logic [4:0] frame_last = 5'h18;
  localparam logic [4:0] word_edge = 5'h17;
  localparam logic [4:0] tx_load = 5'h07;
  // register addresses and pages
  localparam logic [6:0] adr_convert_page_control = 7'h01;
  localparam logic [6:0] adr_gpio = 7'h04;
  localparam logic [6:0] adr_angle = 7'h05;
  localparam logic [6:0] adr_fault = 7'h06;
  localparam logic [6:0] adr_sine = 7'h10;
  localparam logic [6:0] adr_cosine = 7'h11;
  localparam logic [6:0] adr_radius = 7'h18;
  localparam logic [6:0] adr_temp = 7'h20;
  localparam logic [6:0] adr_general = 7'h10;
  localparam logic [6:0] adr_pinfn = 7'h12;
  localparam logic [6:0] adr_correction_disable_key = 7'h23;
  localparam logic [4:0] page_meas = 5'h00;
  localparam logic [4:0] page_cfg = 5'h02;
  // reset, preset and key values
  localparam logic [15:0] rst_fault = 16'hffff;
  localparam logic [15:0] rst_general = 16'h1230;
  localparam logic [15:0] rst_pinfn = 16'h201f;
  localparam logic [15:0] rst_angle = 16'h8000;
  localparam logic [15:0] preset_trig = 16'h2000;
  localparam logic [15:0] preset_temp = 16'hfff0;
  localparam logic [15:0] ecc_key = 16'h4d54;
  localparam logic [15:0] mask_pinfn = 16'h3f3f;
  // field positions and codes
  localparam int cnv_hi = 15;
  localparam int cnv_lo = 14;
  localparam int page_hi = 4;
  localparam logic [1:0] cnv_start = 2'h0;
  localparam logic [1:0] cnv_abort = 2'h3;
  localparam int gen_sync_hi = 14;
  localparam int gen_sync_lo = 13;
  localparam logic [1:0] sync_edge = 2'h3;
  localparam int gen_filt = 12;
  localparam int gen_h8 = 10;
  localparam int gen_mode = 0;
  localparam int flag_bit = 0;
  localparam int pin_en_lo = 8;
  localparam int pin_boot = 5;
  localparam int pin_done = 3;
  localparam int pin_cnv = 1;
  localparam int pin_busy = 0;
  localparam logic [5:0] fn_outputs = 6'h29;
  localparam int f_radius = 14;
  localparam int f_cross = 13;
  localparam int f_false = 9;
  localparam int f_ecc2 = 7;
  localparam int f_crc = 5;
  localparam int f_iov = 3;
  localparam int f_iuv = 2;
  localparam int f_cov = 1;
  localparam int f_cuv = 0;
  // carriers
  typedef struct packed {logic wr; logic [6:0] adr; logic [15:0] data;} link_word_t;
  typedef struct packed {
    logic [13:0] sine; logic [13:0] cosine; logic [14:0] radius; logic [11:0] temp;
    logic [11:0] angle;
  } meas_t;
  typedef struct packed {
    logic turn_mismatch; logic turn_range; logic decoder_split; logic combo_error;
    logic quadrant_error; logic false_state; logic ref_flip; logic dir_illegal;
    logic turn_low; logic radius_fail; logic ecc_double; logic nvm_crc;
    logic iface_ov; logic iface_uv; logic core_ov; logic core_uv;
  } fault_src_t;
  typedef struct packed {
    logic sample_on_edge; logic angle_filter_on; logic eighth_harmonic_source;
    logic conversion_mode_select;
  } cfg_t;
  typedef enum logic [1:0] {seq_idle = 2'h1, seq_run = 2'h2} seq_t;
endpackage

// *** hw/bit_sync.sv ***
// three-stage synchroniser, a change counts once stages two and three agree
`timescale 1ns/100ps
module bit_sync #(parameter int unsigned W = 1) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // foreign level in, settled level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level
);
  typedef struct packed {logic [W-1:0] s1; logic [W-1:0] s2; logic [W-1:0] s3; logic [W-1:0] lvl;} sync_t;
  sync_t sync_q, sync_d;

  // stage one feeds only stage two
  always_comb begin
    sync_d = sync_q;
    sync_d.s1 = async_in;
    sync_d.s2 = sync_q.s1;
    sync_d.s3 = sync_q.s2;
    for (int i = 0; i < W; i++) begin
      if (sync_q.s2[i] == sync_q.s3[i]) begin
        sync_d.lvl[i] = sync_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign level = sync_q.lvl;
endmodule

// *** hw/spi_link.sv ***
// serial link slave on the host's clock, one 24-bit frame per select
`timescale 1ns/100ps
module spi_link (
  // link clock and framing
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic reset,
  // serial answer
  output logic miso,
  output logic miso_oe,
  // finished frame out, answer word in
  output logic req_tgl,
  output mt_pkg::link_word_t req_word,
  input wire logic [15:0] rd_word
);
  typedef struct packed {logic [4:0] cnt; logic [22:0] rx; logic [15:0] tx;} frame_t;
  typedef struct packed {logic tgl; mt_pkg::link_word_t word;} hold_t;
  frame_t frame_q, frame_d;
  hold_t hold_q, hold_d;

  // shift in on each rising edge; the answer follows the address byte
  always_comb begin
    frame_d = frame_q;
    hold_d = hold_q;
    frame_d.rx = {frame_q.rx[21:0], mosi};
    if (frame_q.cnt != mt_pkg::frame_last) begin
      frame_d.cnt = frame_q.cnt + 5'h01;
    end
    if (frame_q.cnt == mt_pkg::tx_load) begin
      frame_d.tx = rd_word;
    end else begin
      frame_d.tx = {frame_q.tx[14:0], 1'b0};
    end
    // word and toggle change together, so the far side sees a whole word
    if (frame_q.cnt == mt_pkg::word_edge) begin
      hold_d.word = {frame_q.rx, mosi};
      hold_d.tgl = ~hold_q.tgl;
    end
  end

  // the clock stops between frames, so the select itself ends the count
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      frame_q <= '0;
    end else begin
      frame_q <= frame_d;
    end
  end

  // the request survives between frames
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_d;
    end
  end

  assign miso = frame_q.tx[15];
  assign miso_oe = ~cs_n;
  assign req_tgl = hold_q.tgl;
  assign req_word = hold_q.word;
endmodule

// *** testbench/spi_host.sv ***
// serial link host model that drives register frames
`timescale 1ns/100ps
module spi_host (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // the clock stands still between frames
  // select rises after time zero so the frame counter sees its clearing edge
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    #1 cs_n = 1'b1;
  end
  // one 24-bit frame, msb first; answer sampled on falling edges 8 to 23
  task automatic xfer(input logic [23:0] f, output logic [15:0] a);
    a = 16'h0;
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi = f[i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      if (i < 17 && i > 0) a[i-1] = miso;
    end
    cs_n = 1'b1;
    mosi = ~mosi; // released line must not hold its last value
    #400;
  endtask
endmodule

// *** testbench/multiturn_sensor_status_config_regs_bench.sv ***
// self-checking bench for the sensor register block
`timescale 1ns/100ps
module multiturn_sensor_status_config_regs_bench;
  logic clk_sys = 1'b0;
  logic reset = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe, seq_start, seq_abort, ecc_off;
  logic [5:0] pin_in, pin_out, pin_oe;
  logic [5:0] ext = 6'h15;
  logic boot_load_in = 1'b1;
  logic meas_valid = 1'b0;
  mt_pkg::meas_t meas = '0;
  mt_pkg::fault_src_t fault_src = '0;
  mt_pkg::cfg_t cfg;
  int failures = 0;
  int check_count = 0;
  int starts = 0;
  int aborts = 0;
  always #20 clk_sys = ~clk_sys;
  // pin level: ours where driven, else the outside source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  // count sequencer pulses, a stuck pulse shows as an extra count
  always @(posedge clk_sys) begin
    starts <= starts + int'(seq_start);
    aborts <= aborts + int'(seq_abort);
  end
  sensor_regs sensor_regs_inst (.clk_sys(clk_sys), .reset(reset), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .boot_load_in(boot_load_in), .meas_valid(meas_valid), .meas(meas),
    .fault_src(fault_src), .seq_start(seq_start), .seq_abort(seq_abort), .cfg(cfg),
    .ecc_off(ecc_off));
  spi_host spi_host_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  task automatic tally_and_finish;
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    spi_host_inst.xfer({1'b1, a, d}, x);
  endtask
  // reads are pipelined, so a second frame fetches the answer
  task automatic rdchk(input string n, input logic [6:0] a, input logic [15:0] e);
    logic [15:0] g;
    spi_host_inst.xfer({1'b0, a, 16'h0}, g);
    spi_host_inst.xfer({1'b0, 7'h7f, 16'h0}, g);
    chk(n, e, g);
  endtask
  // page 01 code in the command bits neither starts nor aborts
  task automatic page(input logic [4:0] p);
    wr(7'h01, {11'h200, p});
  endtask
  task automatic pulse(input mt_pkg::meas_t m);
    @(posedge clk_sys) #1 meas = m;
    meas_valid = 1'b1;
    @(posedge clk_sys) #1 meas_valid = 1'b0;
  endtask
  task automatic t_reset;
    rdchk("fault", 7'h06, 16'hffff);
    rdchk("angle", 7'h05, 16'h8000);
    page(5'h02);
    rdchk("general", 7'h10, 16'h1230);
    rdchk("pinfn", 7'h12, 16'h201f);
    rdchk("offpage", 7'h20, 16'h0);
    chk("cfg", 16'h4, {12'h0, cfg});
    chk("oe", 16'h20, {10'h0, pin_oe});
    chk("pins", 16'h20, {10'h0, pin_out});
    chk("miso oe", 16'h0, {15'h0, miso_oe});
    @(posedge clk_sys) #1 boot_load_in = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk("boot", 16'h0, {10'h0, pin_out});
    boot_load_in = 1'b1;
  endtask
  task automatic t_fault;
    int b;
    for (int j = 0; j < 16; j++) begin
      b = j > 10 ? 13 : j > 6 ? 9 : j == 6 ? 14 : j == 5 ? 7 : j == 4 ? 5 : j;
      @(posedge clk_sys) #1 fault_src = mt_pkg::fault_src_t'(16'h1 << j);
      wr(7'h06, 16'h0);
      @(posedge clk_sys) #1 fault_src = '0;
      rdchk("fault", 7'h06, 16'h1 << b);
      wr(7'h06, 16'h5a5a);
      rdchk("kept", 7'h06, 16'h1 << b);
      wr(7'h06, 16'h0);
    end
  endtask
  task automatic t_seq;
    page(5'h00);
    wr(7'h01, 16'h0);
    chk("starts", 16'h1, 16'(starts));
    rdchk("sine pre", 7'h10, 16'h2000);
    rdchk("temp pre", 7'h20, 16'hfff0);
    pulse('{14'h1abc, 14'h2345, 15'h5678, 12'h9de, 12'h321});
    rdchk("sine", 7'h10, {14'h1abc, 2'h1});
    rdchk("sine rd", 7'h10, {14'h1abc, 2'h0});
    rdchk("cosine", 7'h11, {14'h2345, 2'h1});
    rdchk("radius", 7'h18, {15'h5678, 1'h1});
    rdchk("temp", 7'h20, {12'h9de, 4'h0});
    rdchk("angle", 7'h05, {12'h321, 4'h0});
    wr(7'h01, 16'hc000);
    chk("aborts", 16'h1, 16'(aborts));
  endtask
  task automatic t_cfg;
    page(5'h02);
    wr(7'h23, 16'h4d54);
    chk("key", 16'h1, {15'h0, ecc_off});
    wr(7'h10, 16'hefff);
    rdchk("general", 7'h10, 16'hefff);
    chk("cfg", 16'hb, {12'h0, cfg});
    wr(7'h12, 16'hff3f);
    rdchk("pinfn", 7'h12, 16'h3f3f);
    wr(7'h04, 16'h002a);
    chk("gpio out", 16'h2a, {10'h0, pin_out});
    wr(7'h12, 16'h003f);
    rdchk("gpio in", 7'h04, 16'h0015);
    chk("oe off", 16'h0, {10'h0, pin_oe});
    wr(7'h23, 16'h0);
    wr(7'h10, 16'h1230);
    rdchk("locked", 7'h10, 16'hefff);
    page(5'h00);
    wr(7'h01, 16'h0);
    pulse('{14'h0123, 14'h0456, 15'h0789, 12'h0ab, 12'h0cd});
    rdchk("one shot", 7'h10, {14'h0123, 2'h0});
    pulse('{14'h3333, 14'h0456, 15'h0789, 12'h0ab, 12'h0cd});
    rdchk("stopped", 7'h10, {14'h0123, 2'h0});
  endtask
  // convert pin in its own function: a fall starts, a rise aborts a running sequence
  task automatic t_pin;
    page(5'h02);
    wr(7'h23, 16'h4d54);
    wr(7'h12, 16'h003d);
    @(posedge clk_sys) #1 ext[1] = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 ext[1] = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 chk("cnv start", 16'h3, 16'(starts));
    ext[1] = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 chk("cnv abort", 16'h2, 16'(aborts));
    chk("cnv idle", 16'h3, 16'(starts));
  endtask
  // reset rises after time zero so every asynchronous reset sees its edge
  initial begin
    #1 reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (5) @(posedge clk_sys);
    t_reset;
    t_fault;
    t_seq;
    t_cfg;
    t_pin;
    rdchk("unmapped", 7'h7f, 16'h0);
    tally_and_finish;
  end
  // hang guard
  initial begin
    #2ms;
    failures++;
    tally_and_finish;
  end
endmodule
